// file: hdl/itc_pkg.sv
// constants and carrier types for the instruction tag capture block
// Contract
// - executing the tag-go command turns the two shared tag pins into tagging inputs.
// - both tag inputs are sampled at the falling edge of the bus phase clock with the fetched program word.
// - a low tag input marks its byte: high tag for the upper byte, low tag for the lower byte, both or none.
// - each tag input is interpreted on its own, never affected by the other.
// - tagging works in every operating mode of the device.
// - tagging is switched off as soon as background debug mode becomes active.
// - while tagging is active no background debug serial command is processed.
// - the high tag shares the background debug pin; the low tag shares port e bit three with the low-byte strobe.
// - the low-byte strobe is driven on the shared pin from a quarter cycle before to a quarter after each rising edge.
// - each tag mark travels with its instruction byte through the instruction queue.
// - a tagged instruction reaching the queue head makes the cpu enter background debug mode instead of running it.
package itc_pkg;
  localparam int unsigned ITC_QDEPTH = 3;
  localparam int unsigned ITC_IDX_W = 2;
  localparam logic [ITC_IDX_W-1:0] ITC_IDX_ZERO = 2'h0;
  localparam logic [ITC_IDX_W-1:0] ITC_IDX_ONE = 2'h1;
  localparam logic [ITC_IDX_W-1:0] ITC_IDX_FULL = 2'h3;
  localparam logic [15:0] ITC_WORD_RST = 16'h0000;
  localparam logic ITC_BIT_RST = 1'b0;
  localparam logic [1:0] ITC_MARK_NONE = 2'h0;
  localparam int unsigned ITC_MARK_HI = 1;
  localparam int unsigned ITC_MARK_LO = 0;

  // one queue entry: program word and its two byte marks
  typedef struct packed {
    logic [15:0] word;
    logic [1:0] mark;
  } itc_entry_t;

  localparam itc_entry_t ITC_ENTRY_RST = '{word: ITC_WORD_RST, mark: ITC_MARK_NONE};

  typedef enum logic [1:0] {
    ITC_ST_IDLE = 2'b00,
    ITC_ST_TAGGING = 2'b01,
    ITC_ST_DEBUG = 2'b10
  } itc_state_t;
endpackage

// file: hdl/itc_tag_capture.sv
// instruction tag capture, marked queue and debug entry request
`timescale 1ns/1ps
module itc_tag_capture (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // debug control from the serial debug engine and cpu
  input wire logic tag_go_command,
  input wire logic background_debug_mode,
  input wire logic serial_cmd_valid,
  // bus phase clock (sampled synchronously)
  input wire logic bus_phase_clock,
  input wire logic bus_phase_quarter,
  // fetch and queue control from the cpu
  input wire logic [15:0] fetch_word,
  input wire logic queue_pop,
  input wire logic queue_flush,
  // shared pins
  input wire logic background_debug_pin_in,
  output logic background_debug_pin_oe,
  input wire logic port_e_bit_three_in,
  output logic port_e_bit_three_out,
  output logic port_e_bit_three_oe,
  input wire logic low_byte_strobe,
  input wire logic port_e_bit_three_data,
  input wire logic port_e_bit_three_drive,
  input wire logic debug_pin_drive,
  // results
  output logic tagging_active,
  output logic serial_cmd_accept,
  output logic debug_entry,
  output logic [15:0] head_word,
  output logic head_valid
);
  // control state and queue bookkeeping
  itc_pkg::itc_state_t state_reg;
  itc_pkg::itc_state_t state_next;
  itc_pkg::itc_entry_t queue_reg [itc_pkg::ITC_QDEPTH];
  logic [itc_pkg::ITC_IDX_W-1:0] count_reg;
  logic [itc_pkg::ITC_IDX_W-1:0] count_next;
  // last sampled bus phase clock level, for the fall detector
  logic bus_clk_prev_reg;
  // flops behind every output
  logic tagging_reg;
  logic bdp_oe_reg;
  logic lo_pin_out_reg;
  logic lo_pin_oe_reg;
  logic accept_reg;
  logic entry_reg;
  logic hvalid_reg;
  logic [15:0] hword_reg;
  // next values of the output flops
  logic tagging_next;
  logic bdp_oe_next;
  logic lo_pin_out_next;
  logic accept_next;
  logic entry_next;
  logic hvalid_next;
  // decoded strobes
  logic bus_clk_fall;
  logic tagging;
  logic mark_hi;
  logic mark_lo;
  logic [1:0] new_mark;
  logic push;
  logic pop;
  logic head_tagged;
  logic do_break;
  logic [itc_pkg::ITC_IDX_W-1:0] pop_step;
  logic [itc_pkg::ITC_IDX_W-1:0] push_step;
  logic [itc_pkg::ITC_IDX_W-1:0] wr_idx;
  logic strobe_win;
  logic lo_pin_drive;

  // a fall is a high level at the last edge and a low level now
  assign bus_clk_fall = bus_clk_prev_reg & ~bus_phase_clock;
  assign tagging = (state_reg == itc_pkg::ITC_ST_TAGGING);

  // marks are active low, one per pin, with no cross term between the pins
  assign mark_hi = tagging & ~background_debug_pin_in;
  assign mark_lo = tagging & ~port_e_bit_three_in;
  assign new_mark[itc_pkg::ITC_MARK_HI] = mark_hi;
  assign new_mark[itc_pkg::ITC_MARK_LO] = mark_lo;

  // a capture into a full queue is dropped; a pop from an empty one is ignored
  assign push = bus_clk_fall & (count_reg != itc_pkg::ITC_IDX_FULL);
  assign pop = queue_pop & (count_reg != itc_pkg::ITC_IDX_ZERO);
  assign head_tagged = |queue_reg[0].mark;

  // a tagged head breaks instead of going to execution; a flush cancels it
  assign do_break = pop & head_tagged & ~queue_flush;

  // write slot is the first free entry once this cycle's pop has shifted
  assign pop_step = pop ? itc_pkg::ITC_IDX_ONE : itc_pkg::ITC_IDX_ZERO;
  assign push_step = push ? itc_pkg::ITC_IDX_ONE : itc_pkg::ITC_IDX_ZERO;
  assign wr_idx = count_reg - pop_step;

  // strobe owns the low tag pin around each rising edge; the tool keeps off then
  assign strobe_win = bus_phase_quarter;
  assign lo_pin_drive = strobe_win | (~tagging & port_e_bit_three_drive);
  assign lo_pin_out_next = strobe_win ? low_byte_strobe : port_e_bit_three_data;

  // output next values; the debug pin turns into an input while tagging
  assign tagging_next = (state_next == itc_pkg::ITC_ST_TAGGING);
  assign bdp_oe_next = debug_pin_drive & ~tagging_next;
  assign accept_next = serial_cmd_valid & ~tagging;
  assign entry_next = do_break;
  assign hvalid_next = pop & ~head_tagged & ~queue_flush;

  // control state; no operating mode input gates the capture
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      itc_pkg::ITC_ST_IDLE: begin
        if (tag_go_command & ~background_debug_mode) begin
          state_next = itc_pkg::ITC_ST_TAGGING;
        end
      end
      itc_pkg::ITC_ST_TAGGING: begin
        // debug mode, from outside or from a break, ends tagging at once
        if (background_debug_mode | do_break) begin
          state_next = itc_pkg::ITC_ST_DEBUG;
        end
      end
      itc_pkg::ITC_ST_DEBUG: begin
        if (~background_debug_mode) begin
          state_next = itc_pkg::ITC_ST_IDLE;
        end
      end
      default: begin
        state_next = itc_pkg::ITC_ST_IDLE;
      end
    endcase
  end

  // queue occupancy; a flush empties it so no stale mark can fire
  always_comb begin
    if (queue_flush) begin
      count_next = itc_pkg::ITC_IDX_ZERO;
    end else begin
      count_next = wr_idx + push_step;
    end
  end

  // control flops; the fall detector resets low so no false fall follows reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= itc_pkg::ITC_ST_IDLE;
      count_reg <= itc_pkg::ITC_IDX_ZERO;
      bus_clk_prev_reg <= itc_pkg::ITC_BIT_RST;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      bus_clk_prev_reg <= bus_phase_clock;
    end
  end

  // queue entries shift toward the head with their marks attached
  genvar gi;
  generate
    for (gi = 0; gi < itc_pkg::ITC_QDEPTH; gi++) begin : g_q
      localparam int unsigned SLOT_I = gi;
      localparam logic [itc_pkg::ITC_IDX_W-1:0] SLOT = SLOT_I[itc_pkg::ITC_IDX_W-1:0];
      itc_pkg::itc_entry_t behind;
      itc_pkg::itc_entry_t nxt;
      // the tail refills with an empty entry as the queue advances
      if (gi + 1 < itc_pkg::ITC_QDEPTH) begin : g_mid
        assign behind = queue_reg[gi + 1];
      end else begin : g_tail
        assign behind = itc_pkg::ITC_ENTRY_RST;
      end
      // flush beats a fresh capture, which beats the shift
      always_comb begin
        nxt = queue_reg[gi];
        if (pop) begin
          nxt = behind;
        end
        if (push && (wr_idx == SLOT)) begin
          nxt = '{word: fetch_word, mark: new_mark};
        end
        if (queue_flush) begin
          nxt = itc_pkg::ITC_ENTRY_RST;
        end
      end
      // one flop row per entry
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          queue_reg[gi] <= itc_pkg::ITC_ENTRY_RST;
        end else begin
          queue_reg[gi] <= nxt;
        end
      end
    end
  endgenerate

  // pin control flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bdp_oe_reg <= itc_pkg::ITC_BIT_RST;
      lo_pin_out_reg <= itc_pkg::ITC_BIT_RST;
      lo_pin_oe_reg <= itc_pkg::ITC_BIT_RST;
    end else begin
      bdp_oe_reg <= bdp_oe_next;
      lo_pin_out_reg <= lo_pin_out_next;
      lo_pin_oe_reg <= lo_pin_drive;
    end
  end

  // result flops; pulses stand for one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tagging_reg <= itc_pkg::ITC_BIT_RST;
      accept_reg <= itc_pkg::ITC_BIT_RST;
      entry_reg <= itc_pkg::ITC_BIT_RST;
      hvalid_reg <= itc_pkg::ITC_BIT_RST;
      hword_reg <= itc_pkg::ITC_WORD_RST;
    end else begin
      tagging_reg <= tagging_next;
      accept_reg <= accept_next;
      entry_reg <= entry_next;
      hvalid_reg <= hvalid_next;
      // copied every cycle so the popped word stands with the pulse
      hword_reg <= queue_reg[0].word;
    end
  end

  // every output comes straight from a flop
  assign tagging_active = tagging_reg;
  assign background_debug_pin_oe = bdp_oe_reg;
  assign port_e_bit_three_out = lo_pin_out_reg;
  assign port_e_bit_three_oe = lo_pin_oe_reg;
  assign serial_cmd_accept = accept_reg;
  assign debug_entry = entry_reg;
  assign head_valid = hvalid_reg;
  assign head_word = hword_reg;
endmodule

// file: dv/itc_checker.sv
// port assertions for the tag capture block
`timescale 1ns/1ps
module itc_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // controls
  input wire logic tag_go_command,
  input wire logic background_debug_mode,
  input wire logic serial_cmd_valid,
  input wire logic bus_phase_quarter,
  input wire logic queue_pop,
  input wire logic queue_flush,
  // pin enables and results
  input wire logic background_debug_pin_oe,
  input wire logic port_e_bit_three_oe,
  input wire logic tagging_active,
  input wire logic serial_cmd_accept,
  input wire logic debug_entry,
  input wire logic head_valid
);
  // one domain, so one clock and one reset for all
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  go_starts_a: assert property ($rose(tagging_active) |-> $past(tag_go_command)) else $error("tag start");
  debug_mode_stops_a: assert property (background_debug_mode |=> !tagging_active) else $error("debug stop");
  serial_blocked_a: assert property (tagging_active && serial_cmd_valid |=> !serial_cmd_accept) else $error("srl");
  break_cause_a: assert property (debug_entry |-> $past(queue_pop) && !head_valid) else $error("break");
  break_ends_a: assert property (debug_entry |-> !tagging_active) else $error("break end");
  exec_cause_a: assert property (head_valid |-> $past(queue_pop)) else $error("exec");
  flush_kills_a: assert property (queue_flush |=> !debug_entry && !head_valid) else $error("flush");
  strobe_window_a: assert property (bus_phase_quarter |=> port_e_bit_three_oe) else $error("strobe");
  pin_input_a: assert property (tagging_active && $past(tagging_active) |-> !background_debug_pin_oe) else $error("pin");
endmodule
bind itc_tag_capture itc_checker itc_checker_i (.mclk, .rst_n, .tag_go_command, .background_debug_mode,
  .serial_cmd_valid, .bus_phase_quarter, .queue_pop, .queue_flush, .background_debug_pin_oe,
  .port_e_bit_three_oe, .tagging_active, .serial_cmd_accept, .debug_entry, .head_valid);

// file: dv/itc_tool_model.sv
// behavioural debug tool driving the two tag pins
`timescale 1ns/1ps
module itc_tool_model (
  // tag request from the bench
  input wire logic [1:0] mark,
  input wire logic drive,
  input wire logic quiet,
  // device pin drivers
  input wire logic dbg_pin_oe,
  input wire logic dbg_pin_out,
  input wire logic lo_pin_oe,
  input wire logic lo_pin_out,
  // resolved pin levels
  output logic dbg_pin_lvl,
  output logic lo_pin_lvl
);
  // marks are active low; released pins float to their pull-ups
  wire tool_on = drive && !quiet; // keeps off the pin in the strobe window
  assign dbg_pin_lvl = dbg_pin_oe ? dbg_pin_out : (tool_on ? !mark[1] : 1'b1);
  assign lo_pin_lvl = lo_pin_oe ? lo_pin_out : (tool_on ? !mark[0] : 1'b1);
endmodule

// file: dv/testbench.sv
// self-checking bench for the tag capture block
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic dbg_mode = 1'b0;
  logic scv = 1'b0;
  logic bpc = 1'b0;
  logic bpq = 1'b0;
  logic pop = 1'b0;
  logic flush = 1'b0;
  logic tdrv = 1'b0;
  logic dpd = 1'b0;
  logic [1:0] tmark = 2'h0;
  logic [15:0] fw = 16'h0000;
  logic [15:0] hw;
  logic bk_lvl;
  logic pe_lvl;
  logic bk_oe;
  logic pe_out;
  logic pe_oe;
  logic act;
  logic acc;
  logic dent;
  logic hv;
  int fail_count = 0;
  int samples_checked = 0;

  // 100 MHz clock
  initial begin
    forever begin
      #5 mclk = ~mclk;
    end
  end

  // the normal debug pin owner wants the pin outside tagging, so the release is seen
  itc_tag_capture itc_tag_capture_i (.mclk, .rst_n, .tag_go_command(go), .background_debug_mode(dbg_mode),
    .serial_cmd_valid(scv), .bus_phase_clock(bpc), .bus_phase_quarter(bpq), .fetch_word(fw), .queue_pop(pop),
    .queue_flush(flush), .background_debug_pin_in(bk_lvl), .background_debug_pin_oe(bk_oe),
    .port_e_bit_three_in(pe_lvl), .port_e_bit_three_out(pe_out), .port_e_bit_three_oe(pe_oe),
    .low_byte_strobe(1'b1), .port_e_bit_three_data(1'b0), .port_e_bit_three_drive(1'b0), .debug_pin_drive(dpd),
    .tagging_active(act), .serial_cmd_accept(acc), .debug_entry(dent), .head_word(hw), .head_valid(hv));
  itc_tool_model itc_tool_model_i (.mark(tmark), .drive(tdrv), .quiet(bpq), .dbg_pin_oe(bk_oe),
    .dbg_pin_out(1'b0), .lo_pin_oe(pe_oe), .lo_pin_out(pe_out), .dbg_pin_lvl(bk_lvl), .lo_pin_lvl(pe_lvl));

  // compare of one-bit results; unknowns fail through the case inequality
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // compare of word results
  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // wait whole cycles; every change lands on a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // strobe quarter first, then the fall that captures word and pins
  task automatic fetch(input logic [15:0] w, input logic [1:0] m);
    bpc = 1'b1;
    bpq = 1'b1;
    cyc(1);
    bpq = 1'b0;
    chk_bit("port_e_bit_three_oe", 1'b1, pe_oe);
    chk_bit("port_e_bit_three_out", 1'b1, pe_out);
    cyc(1);
    chk_bit("port_e_bit_three_oe", 1'b0, pe_oe);
    bpc = 1'b0;
    fw = w;
    tmark = m;
    tdrv = 1'b1;
    cyc(1);
    tdrv = 1'b0;
  endtask

  // one pop; a spare cycle keeps two pops in a row apart
  task automatic pop1(input logic e, input logic [15:0] w);
    pop = 1'b1;
    cyc(1);
    pop = 1'b0;
    chk_bit("debug_entry", e, dent);
    chk_bit("head_valid", !e, hv);
    if (!e) begin
      chk_word("head_word", w, hw);
    end
    cyc(1);
  endtask

  // tag-go turns the pins into tag inputs and releases the debug pin
  task automatic start;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(1);
    chk_bit("tagging_active", 1'b1, act);
    chk_bit("background_debug_pin_oe", 1'b0, bk_oe);
  endtask

  // debug mode ends tagging at the very next edge
  task automatic leave;
    dbg_mode = 1'b1;
    cyc(1);
    chk_bit("tagging_active", 1'b0, act);
    chk_bit("background_debug_pin_oe", 1'b1, bk_oe);
    cyc(1);
    dbg_mode = 1'b0;
    cyc(1);
  endtask

  // every tag code once: none, low byte, high byte, both
  task automatic t_codes;
    for (int i = 0; i < 4; i++) begin
      start;
      fetch({14'h2a5c, i[1:0]}, i[1:0]);
      pop1(i != 0, {14'h2a5c, i[1:0]});
      leave;
    end
    $display("codes done");
  endtask

  // serial commands are refused while tagging and taken afterwards
  task automatic t_serial;
    start;
    scv = 1'b1;
    cyc(1);
    scv = 1'b0;
    chk_bit("serial_cmd_accept", 1'b0, acc);
    leave;
    scv = 1'b1;
    cyc(1);
    scv = 1'b0;
    chk_bit("serial_cmd_accept", 1'b1, acc);
    $display("serial done");
  endtask

  // a full queue drains in order and the tagged tail breaks
  task automatic t_order;
    start;
    fetch(16'h1111, 2'h0);
    fetch(16'h2222, 2'h0);
    fetch(16'h3333, 2'h1);
    pop1(1'b0, 16'h1111);
    pop1(1'b0, 16'h2222);
    pop1(1'b1, 16'h0000);
    leave;
    $display("order done");
  endtask

  // a flushed tagged word never breaks
  task automatic t_flush;
    start;
    fetch(16'h4444, 2'h3);
    flush = 1'b1;
    cyc(1);
    flush = 1'b0;
    fetch(16'h5555, 2'h0);
    pop1(1'b0, 16'h5555);
    leave;
    $display("flush done");
  endtask

  // verdict, the one place where the run ends
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence after 12 reset cycles
  initial begin
    cyc(12);
    rst_n = 1'b1;
    dpd = 1'b1;
    cyc(1);
    t_codes;
    t_serial;
    t_order;
    t_flush;
    finish_test;
  end

  // watchdog far beyond the fewer than a hundred cycles the scenarios take
  initial begin
    #100us;
    fail_count++;
    finish_test;
  end
endmodule
